// ### dv/ehm_error_history_tb_top.sv
// Self-checking bench for the error history memory
`timescale 1ns/1ps
module ehm_error_history_tb_top;
  import ehm_pkg::*;
  // Short erase keeps the busy poll brief
  localparam int CLR_N = 4;
  localparam logic [15:0] DET [11] = '{OFS_ENTRY_CLASS, OFS_ENTRY_DETECT_TIME,
    OFS_ENTRY_QUALIFIER, OFS_ENTRY_ENABLE_CYCLES, OFS_ENTRY_TIME_SINCE_EN,
    OFS_ENTRY_BUS_VOLTAGE, OFS_ENTRY_MOTOR_SPEED, OFS_ENTRY_MOTOR_CURRENT,
    OFS_ENTRY_POWER_STAGE_TEMP, OFS_ENTRY_DEVICE_TEMP, OFS_POWER_ON_CYCLE_COUNT};
  logic        clk, resetn, factoryResetn, evtValid, parRead, parWrite, parAck, hang;
  logic [15:0] parAddr, lastStop;
  logic [31:0] parWdata, parRdata, rd;
  ehm_entry_s  ev, e;
  ehm_entry_s  hist[$];
  int          fail_count, tests_run, polls;

  ehm_error_history #(.DEPTH(HIST_DEPTH), .CLEAR_CYCLES(CLR_N)) dut (
    .clk(clk), .resetn(resetn), .factoryResetn(factoryResetn), .evtValid(evtValid),
    .evtClass(ev.cls), .evtCode(ev.code), .evtCurrent(ev.current),
    .evtBusVoltage(ev.busVoltage), .evtSpeed(ev.speed), .evtDevTemp(ev.devTemp),
    .evtPaTemp(ev.paTemp), .evtQualifier(ev.qualifier), .evtTime(ev.detectTime),
    .evtPowerOnCount(ev.powerOnCount), .evtEnableCycles(ev.enableCycles),
    .evtTimeSinceEnable(ev.timeSinceEnable), .parRead(parRead), .parWrite(parWrite),
    .parAddr(parAddr), .parWdata(parWdata), .parAck(parAck), .parRdata(parRdata));

  ehm_master_model m (.clk(clk), .parAck(parAck), .parRdata(parRdata), .parRead(parRead),
    .parWrite(parWrite), .parAddr(parAddr), .parWdata(parWdata), .hang(hang));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Negative temperatures and speed check zero-extended signed fields
  function automatic ehm_entry_s mk(input logic [2:0] c, input logic [15:0] k);
    return '{c, k, k ^ 16'h00A5, k + 16'h0011, ~k, 16'hFF00 | {8'h00, k[7:0]},
             k - 16'h0101, {k[7:0], k[15:8]}, {k, ~k}, {~k, k}, k + 16'h0300,
             k ^ 16'h5A5A};
  endfunction

  function automatic logic [31:0] fld(input ehm_entry_s r, input int i);
    case (i)
      0: return {29'h0, r.cls};
      1: return (r.detectTime > DETECT_TIME_MAX) ? DETECT_TIME_MAX : r.detectTime;
      2: return {16'h0000, r.qualifier};
      3: return {16'h0000, r.enableCycles};
      4: return {16'h0000, r.timeSinceEnable};
      5: return {16'h0000, r.busVoltage};
      6: return {16'h0000, r.speed};
      7: return {16'h0000, r.current};
      8: return {16'h0000, r.paTemp};
      9: return {16'h0000, r.devTemp};
      default: return r.powerOnCount;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic log_evt(input logic [2:0] c, input logic [15:0] k);
    @(posedge clk);
    ev       <= mk(c, k);
    evtValid <= 1'b1;
    @(posedge clk);
    evtValid <= 1'b0;
    if (c <= CLASS_MAX) hist.push_back(mk(c, k));
    if (hist.size() > HIST_DEPTH) void'(hist.pop_front());
    if (c >= CLASS_STOP_MIN && c <= CLASS_MAX) lastStop = k;
  endtask

  task automatic chk_det(input ehm_entry_s r);
    for (int i = 0; i < 11; i++) begin
      m.rd(DET[i], rd);
      chk(rd, fld(r, i), "entry detail");
    end
  endtask

  task automatic scan;
    m.rewind();
    foreach (hist[i]) begin
      m.rd(OFS_ENTRY_CODE_FETCH, rd);
      chk(rd, {16'h0000, hist[i].code}, "entry code");
      chk_det(hist[i]);
    end
    m.rd(OFS_ENTRY_CODE_FETCH, rd);
    chk(rd, 32'h0000_0000, "end of history");
  endtask

  task automatic chk_stop;
    m.rd(OFS_LAST_STOP_ERROR_CODE, rd);
    chk(rd, {16'h0000, lastStop}, "last stop code");
  endtask

  task automatic finish_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge hang) begin
    fail_count++;
    $display("ERROR %0t: parameter port gave no answer", $time);
    finish_test();
  end

  initial begin
    resetn        = 1'b0;
    factoryResetn = 1'b0;
    evtValid      = 1'b0;
    ev            = '0;
    lastStop      = 16'h0000;
    fail_count    = 0;
    tests_run     = 0;
    repeat (20) @(posedge clk);
    resetn        <= 1'b1;
    factoryResetn <= 1'b1;
    chk_stop();
    scan();
    $display("Test empty history done");
    // Eleven events overflow the ring; codes above 0x2000 saturate the time
    for (int i = 0; i < 11; i++) log_evt(3'(i % 5), 16'h1234 + 16'(i * 16'h0F3B));
    log_evt(3'h5, 16'hBEEF);
    m.wr(OFS_LAST_STOP_ERROR_CODE, 32'h0000_0000);
    chk_stop();
    m.rd(16'h3C00, rd);
    chk(rd, 32'h0000_0000, "unmapped read");
    scan();
    $display("Test overflow scan done");
    m.rewind();
    e = hist[0];
    m.rd(OFS_ENTRY_CODE_FETCH, rd);
    chk(rd, {16'h0000, e.code}, "first code");
    log_evt(3'h2, 16'h7777);
    chk_det(e);
    scan();
    $display("Test buffer hold done");
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    scan();
    chk_stop();
    $display("Test warm reset done");
    m.clear(polls);
    chk(32'(polls > 0 && polls <= CLR_N), 32'h1, "clear busy reads");
    hist.delete();
    scan();
    log_evt(3'h3, 16'h4321);
    scan();
    $display("Test clear done");
    @(posedge clk);
    factoryResetn <= 1'b0;
    @(posedge clk);
    factoryResetn <= 1'b1;
    hist.delete();
    lastStop = 16'h0000;
    chk_stop();
    scan();
    $display("Test factory reset done");
    finish_test();
  end
endmodule // ehm_error_history_tb_top

// ### dv/ehm_master_model.sv
// Parameter-port master model issuing single-cycle requests
`timescale 1ns/1ps
module ehm_master_model
  import ehm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        parAck,
  input  wire logic [31:0] parRdata,
  output logic             parRead,
  output logic             parWrite,
  output logic      [15:0] parAddr,
  output logic      [31:0] parWdata,
  output logic             hang
);
  initial begin
    parRead  = 1'b0;
    parWrite = 1'b0;
    parAddr  = 16'h0000;
    parWdata = 32'h0000_0000;
    hang     = 1'b0;
  end

  // Idle address and data show the inverse, never a stale match
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
    int n;
    @(posedge clk);
    parRead  <= ~w;
    parWrite <= w;
    parAddr  <= a;
    parWdata <= wd;
    @(posedge clk);
    parRead  <= 1'b0;
    parWrite <= 1'b0;
    parAddr  <= ~a;
    parWdata <= ~wd;
    n = 0;
    #1;
    while (parAck !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 8) hang = 1'b1;
    d = parRdata;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0000_0000, d);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] wd);
    logic [31:0] unused;
    xfer(1'b1, a, wd, unused);
  endtask

  // A scan always starts here
  task automatic rewind;
    wr(OFS_READ_POINTER_REWIND, CMD_ACTIVATE);
  endtask

  // Done once the flag reads back zero, or raises hang after 64 busy reads
  task automatic clear(output int busy);
    logic [31:0] d;
    busy = 0;
    wr(OFS_HISTORY_CLEAR, CMD_ACTIVATE);
    rd(OFS_HISTORY_CLEAR, d);
    while (d !== 32'h0000_0000 && busy < 64) begin
      busy++;
      rd(OFS_HISTORY_CLEAR, d);
    end
    if (busy == 64) hang = 1'b1;
  endtask
endmodule // ehm_master_model

// ### rtl/ehm_error_history.sv
// Error history memory: ring of events, fetch buffer and parameter access
//
// Summary of operation
// - Keep last class 1-4 error code
// - Hold ten events in nonvolatile storage
// - Capture all values at detection instant
// - Each fetch of a stored entry advances the read pointer
// - Exhausted history returns error code zero
// - Position one oldest, position ten newest
// - Code read copies entry into buffer
// - Class reported as integer zero to four
// - Current unsigned, hundredths of an ampere
// - Bus voltage unsigned, tenths of a volt
// - Power-on count full 32-bit range
// - Detect time capped at documented maximum
// - Both temperatures signed 16-bit Celsius
// - Velocity signed 16-bit RPM
// - Enable count since switch-on, 16-bit
// - Time since enable, unsigned 16-bit
// - Qualifier 16-bit, code dependent meaning
// - Writing one rewinds pointer to oldest
// - Writing one clears; reads zero when done
`timescale 1ns/1ps
module ehm_error_history
  import ehm_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH,
  parameter int CLEAR_CYCLES = CLEAR_BUSY_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        factoryResetn,
  input  wire logic        evtValid,
  input  wire logic [2:0]  evtClass,
  input  wire logic [15:0] evtCode,
  input  wire logic [15:0] evtCurrent,
  input  wire logic [15:0] evtBusVoltage,
  input  wire logic [15:0] evtSpeed,
  input  wire logic [15:0] evtDevTemp,
  input  wire logic [15:0] evtPaTemp,
  input  wire logic [15:0] evtQualifier,
  input  wire logic [31:0] evtTime,
  input  wire logic [31:0] evtPowerOnCount,
  input  wire logic [15:0] evtEnableCycles,
  input  wire logic [15:0] evtTimeSinceEnable,
  input  wire logic        parRead,
  input  wire logic        parWrite,
  input  wire logic [15:0] parAddr,
  input  wire logic [31:0] parWdata,
  output logic             parAck,
  output logic      [31:0] parRdata
);

  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int CLR_BOUND = CLEAR_CYCLES + 1;
  localparam logic [CNT_W-1:0] PTR_ONE = CNT_W'(1);
  localparam int CLR_W = $clog2(CLEAR_CYCLES + 1);
  localparam logic [CLR_W-1:0] CLR_LAST = CLR_W'(CLEAR_CYCLES - 1);

  ehm_clr_state_e                    clrState_q;
  ehm_clr_state_e                    clrState_d;
  logic [$clog2(CLEAR_CYCLES+1)-1:0] clrCnt_q;
  logic [$clog2(CLEAR_CYCLES+1)-1:0] clrCnt_d;
  logic [CNT_W-1:0]                  rdPtr_q;
  logic [CNT_W-1:0]                  rdPtr_d;
  logic [CNT_W-1:0]                  ptrStep;
  logic [15:0]                       lastStop_q;
  logic [15:0]                       lastStop_d;
  ehm_entry_s                        buf_q;
  ehm_entry_s                        buf_d;
  logic                              parAck_q;
  logic [31:0]                       parRdata_q;
  logic [31:0]                       rdValue;

  ehm_entry_s       captured;
  ehm_entry_s       ringRd;
  ehm_entry_s       fetchEntry;
  logic [CNT_W-1:0] histCount;
  logic             histFull;
  logic             evtAccept;
  logic             evtIsStop;
  logic             pushDrop;
  logic             entryAvail;
  logic             hitCode;
  logic             fetch;
  logic             wrOne;
  logic             rewind;
  logic             clrStart;
  logic             clrBusy;
  logic             ringClrAll;

  // Snapshot of the live values at detection; out-of-range classes are dropped
  assign evtAccept = evtValid && (evtClass <= CLASS_MAX);
  assign evtIsStop = evtAccept && (evtClass >= CLASS_STOP_MIN);
  assign captured.cls             = evtClass;
  assign captured.code            = evtCode;
  assign captured.current         = evtCurrent;
  assign captured.busVoltage      = evtBusVoltage;
  assign captured.speed           = evtSpeed;
  assign captured.devTemp         = evtDevTemp;
  assign captured.paTemp          = evtPaTemp;
  assign captured.qualifier       = evtQualifier;
  // Detection time saturates rather than wrapping past its limit
  assign captured.detectTime      = (evtTime > DETECT_TIME_MAX) ? DETECT_TIME_MAX
                                                                : evtTime;
  assign captured.powerOnCount    = evtPowerOnCount;
  assign captured.enableCycles    = evtEnableCycles;
  assign captured.timeSinceEnable = evtTimeSinceEnable;

  ehm_history_ring #(
    .DEPTH (DEPTH),
    .WIDTH (ENTRY_W),
    .CNT_W (CNT_W)
  ) u_ring (
    .clk      (clk),
    .rstn     (factoryResetn),
    .push     (evtAccept),
    .pushData (captured),
    .clrAll   (ringClrAll),
    .rdIdx    (rdPtr_q),
    .rdData   (ringRd),
    .count    (histCount),
    .full     (histFull)
  );

  // Parameter port decode; a write in the same cycle wins over a read
  assign wrOne      = parWrite && (parWdata == CMD_ACTIVATE);
  assign hitCode    = parAddr == OFS_ENTRY_CODE_FETCH;
  assign fetch      = parRead && !parWrite && hitCode;
  assign rewind     = wrOne && (parAddr == OFS_READ_POINTER_REWIND);
  assign clrBusy    = clrState_q == CLR_BUSY;
  assign clrStart   = wrOne && (parAddr == OFS_HISTORY_CLEAR) && !clrBusy;
  assign ringClrAll = clrStart;
  assign pushDrop   = evtAccept && histFull && !ringClrAll;

  // Past the last stored entry the fetch yields an all-zero entry
  assign entryAvail = rdPtr_q < histCount;
  assign fetchEntry = entryAvail ? ringRd : '0;

  // Pointer counts from the oldest; a dropped oldest shifts it back by one
  assign ptrStep = (fetch && entryAvail) ? PTR_ONE : '0;
  assign rdPtr_d = (rewind || ringClrAll) ? '0
                 : (pushDrop && (rdPtr_q + ptrStep) != '0) ? rdPtr_q + ptrStep - PTR_ONE
                 : rdPtr_q + ptrStep;

  assign buf_d      = fetch ? fetchEntry : buf_q;
  assign lastStop_d = evtIsStop ? evtCode : lastStop_q;

  assign clrState_d = clrStart ? CLR_BUSY
                    : (clrBusy && clrCnt_q == '0) ? CLR_IDLE : clrState_q;
  assign clrCnt_d   = clrStart ? CLR_LAST
                    : (clrBusy && clrCnt_q != '0) ? clrCnt_q - 1'b1 : clrCnt_q;

  // Read mux: code reads the fresh entry, details read the buffer
  assign rdValue =
      hitCode                                ? {16'h0000, fetchEntry.code}
    : (parAddr == OFS_LAST_STOP_ERROR_CODE)  ? {16'h0000, lastStop_q}
    : (parAddr == OFS_POWER_ON_CYCLE_COUNT)  ? buf_q.powerOnCount
    : (parAddr == OFS_HISTORY_CLEAR)         ? {31'h0000_0000, clrBusy}
    : (parAddr == OFS_ENTRY_CLASS)           ? {29'h0000_0000, buf_q.cls}
    : (parAddr == OFS_ENTRY_DETECT_TIME)     ? buf_q.detectTime
    : (parAddr == OFS_ENTRY_QUALIFIER)       ? {16'h0000, buf_q.qualifier}
    : (parAddr == OFS_ENTRY_ENABLE_CYCLES)   ? {16'h0000, buf_q.enableCycles}
    : (parAddr == OFS_ENTRY_TIME_SINCE_EN)   ? {16'h0000, buf_q.timeSinceEnable}
    : (parAddr == OFS_ENTRY_BUS_VOLTAGE)     ? {16'h0000, buf_q.busVoltage}
    : (parAddr == OFS_ENTRY_MOTOR_SPEED)     ? {16'h0000, buf_q.speed}
    : (parAddr == OFS_ENTRY_MOTOR_CURRENT)   ? {16'h0000, buf_q.current}
    : (parAddr == OFS_ENTRY_POWER_STAGE_TEMP)? {16'h0000, buf_q.paTemp}
    : (parAddr == OFS_ENTRY_DEVICE_TEMP)     ? {16'h0000, buf_q.devTemp}
    : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdPtr_q    <= '0;
      buf_q      <= '0;
      clrState_q <= CLR_IDLE;
      clrCnt_q   <= '0;
      parAck_q   <= 1'b0;
      parRdata_q <= 32'h0000_0000;
    end else begin
      rdPtr_q    <= rdPtr_d;
      buf_q      <= buf_d;
      clrState_q <= clrState_d;
      clrCnt_q   <= clrCnt_d;
      parAck_q   <= parRead || parWrite;
      parRdata_q <= (parRead && !parWrite) ? rdValue : 32'h0000_0000;
    end
  end

  // Factory reset also clears the stop code; a warm reset alone keeps it
  always_ff @(posedge clk) begin
    if (!factoryResetn) begin
      lastStop_q <= RST_LAST_STOP_ERROR_CODE;
    end else begin
      lastStop_q <= lastStop_d;
    end
  end

  assign parAck   = parAck_q;
  assign parRdata = parRdata_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || !factoryResetn);

  a_stop_code_latch: assert property (
    evtIsStop |=> lastStop_q == $past(evtCode))
    else $error("stop code not latched from class 1-4 event");

  a_stop_code_hold: assert property (
    (evtValid && evtClass == 3'h0) |=> $stable(lastStop_q))
    else $error("class 0 event changed stop code");

  a_fetch_advances: assert property (
    (fetch && entryAvail && !evtAccept && !rewind && !ringClrAll)
      |=> rdPtr_q == $past(rdPtr_q) + PTR_ONE)
    else $error("fetch did not advance read pointer");

  a_empty_returns_zero: assert property (
    (fetch && !entryAvail) |=> parAck && parRdata == 32'h0000_0000 && buf_q == '0)
    else $error("exhausted history did not return code zero");

  a_buffer_loads_entry: assert property (
    fetch |=> (buf_q == $past(fetchEntry)) && (parRdata[15:0] == buf_q.code))
    else $error("code read did not load the holding buffer");

  a_buffer_stays_put: assert property (
    (!fetch && evtAccept) |=> $stable(buf_q))
    else $error("holding buffer changed without a code read");

  a_rewind_to_oldest: assert property (
    rewind |=> rdPtr_q == '0)
    else $error("rewind did not reset read pointer");

  a_clear_busy_ends: assert property (
    clrStart |=> clrBusy ##[1:CLR_BOUND] !clrBusy)
    else $error("history clear never completed");

  a_clear_empties: assert property (
    (clrStart && !evtAccept) |=> histCount == '0 && rdPtr_q == '0)
    else $error("clear left entries in history");

  a_count_bounded: assert property (
    histCount <= CNT_W'(DEPTH))
    else $error("history holds more than its depth");

  a_detail_in_range: assert property (
    (buf_q.detectTime <= DETECT_TIME_MAX) && (buf_q.cls <= CLASS_MAX))
    else $error("buffered time or class out of range");

  // Out-of-range classes must leave history and stop code untouched
  a_bad_class_ignored: assert property (
    (evtValid && evtClass > CLASS_MAX && !clrStart)
      |=> histCount == $past(histCount) && $stable(lastStop_q))
    else $error("event with class above four was stored");

  a_write_reads_zero: assert property (
    parWrite |=> parAck && parRdata == 32'h0000_0000)
    else $error("write returned nonzero read data");

  // Erase takes at least one cycle, so a read right after must see busy
  a_clear_reads_busy: assert property (
    (clrStart ##1 (parRead && !parWrite && parAddr == OFS_HISTORY_CLEAR))
      |=> parRdata == 32'h0000_0001)
    else $error("clear flag not busy right after clear");

  a_ack_follows: assert property (
    (parRead || parWrite) |=> parAck ##1 !parAck || $past(parRead || parWrite))
    else $error("parameter access not acknowledged");

  c_fetch_entry:   cover property (fetch && entryAvail);
  c_fetch_empty:   cover property (fetch && !entryAvail);
  c_full_drop:     cover property (pushDrop);
  c_clear_done:    cover property (clrBusy ##1 !clrBusy);
  c_rewind_scan:   cover property (rewind ##[1:4] fetch);

endmodule // ehm_error_history

// ### rtl/ehm_history_ring.sv
// Ring of the last events, oldest first, kept across the warm reset
`timescale 1ns/1ps
module ehm_history_ring
  import ehm_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH,
  parameter int WIDTH = ENTRY_W,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] pushData,
  input  wire logic             clrAll,
  input  wire logic [CNT_W-1:0] rdIdx,
  output logic      [WIDTH-1:0] rdData,
  output logic      [CNT_W-1:0] count,
  output logic                  full
);

  // Storage has no reset: it stands for the nonvolatile array
  logic [WIDTH-1:0] mem [DEPTH];
  logic [CNT_W-1:0] wrPtr_q;
  logic [CNT_W-1:0] wrPtr_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] basePtr;
  logic [CNT_W-1:0] baseCnt;
  logic [CNT_W-1:0] oldest;
  logic [CNT_W:0]   sumIdx;
  logic [CNT_W-1:0] physIdx;

  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] ONE_C   = CNT_W'(1);

  assign full    = (count_q == DEPTH_C);
  assign count   = count_q;
  // Once full the write slot is also the oldest slot
  assign oldest  = full ? wrPtr_q : '0;
  assign sumIdx  = {1'b0, oldest} + {1'b0, rdIdx};
  assign physIdx = (sumIdx >= {1'b0, DEPTH_C}) ? CNT_W'(sumIdx - {1'b0, DEPTH_C})
                                                : sumIdx[CNT_W-1:0];
  assign rdData  = mem[physIdx];

  // Clear and push in one cycle: the new event survives the clear
  assign basePtr = clrAll ? '0 : wrPtr_q;
  assign baseCnt = clrAll ? '0 : count_q;
  assign wrPtr_d = push ? ((basePtr == DEPTH_C - ONE_C) ? '0 : basePtr + ONE_C) : basePtr;
  // Overwriting the oldest slot when full keeps the ten newest
  assign count_d = (push && baseCnt != DEPTH_C) ? baseCnt + ONE_C : baseCnt;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[basePtr] <= pushData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      count_q <= count_d;
    end
  end

  a_push_stores_entry: assert property (@(posedge clk) disable iff (!rstn)
    push |=> mem[$past(basePtr)] == $past(pushData))
    else $error("pushed event not stored in its slot");

  a_count_saturates: assert property (@(posedge clk) disable iff (!rstn)
    (push && full && !clrAll) |=> full && (wrPtr_q != $past(wrPtr_q)))
    else $error("full ring did not replace its oldest entry");

endmodule // ehm_history_ring

// ### rtl/ehm_pkg.sv
// Constants and types shared by the error history memory
package ehm_pkg;

  // Parameter addresses on the drive's parameter port
  localparam logic [15:0] OFS_LAST_STOP_ERROR_CODE   = 16'h1C0A;
  localparam logic [15:0] OFS_POWER_ON_CYCLE_COUNT   = 16'h3B04;
  localparam logic [15:0] OFS_HISTORY_CLEAR          = 16'h3B08;
  localparam logic [15:0] OFS_READ_POINTER_REWIND    = 16'h3B0A;
  localparam logic [15:0] OFS_ENTRY_CODE_FETCH       = 16'h3C02;
  localparam logic [15:0] OFS_ENTRY_CLASS            = 16'h3C04;
  localparam logic [15:0] OFS_ENTRY_DETECT_TIME      = 16'h3C06;
  localparam logic [15:0] OFS_ENTRY_QUALIFIER        = 16'h3C08;
  localparam logic [15:0] OFS_ENTRY_ENABLE_CYCLES    = 16'h3C0A;
  localparam logic [15:0] OFS_ENTRY_TIME_SINCE_EN    = 16'h3C0C;
  localparam logic [15:0] OFS_ENTRY_BUS_VOLTAGE      = 16'h3C0E;
  localparam logic [15:0] OFS_ENTRY_MOTOR_SPEED      = 16'h3C10;
  localparam logic [15:0] OFS_ENTRY_MOTOR_CURRENT    = 16'h3C12;
  localparam logic [15:0] OFS_ENTRY_POWER_STAGE_TEMP = 16'h3C14;
  localparam logic [15:0] OFS_ENTRY_DEVICE_TEMP      = 16'h3C16;

  // Reset values and command values
  localparam logic [15:0] RST_LAST_STOP_ERROR_CODE = 16'h0000;
  localparam logic [31:0] CMD_ACTIVATE             = 32'h0000_0001;

  // Error classes and field limits
  localparam logic [2:0]  CLASS_STOP_MIN  = 3'h1;
  localparam logic [2:0]  CLASS_MAX       = 3'h4;
  localparam logic [31:0] DETECT_TIME_MAX = 32'h1FFF_FFFF;
  localparam int          HIST_DEPTH      = 10;

  // Nonvolatile erase time and its cost in clock cycles (least time, rounded up)
  localparam int CLK_PERIOD_NS       = 100;
  localparam int NV_ERASE_TIME_NS    = 2000;
  localparam int CLEAR_BUSY_CYCLES   = (NV_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // One stored event, captured at the instant of detection
  typedef struct packed {
    logic [2:0]  cls;
    logic [15:0] code;
    logic [15:0] current;
    logic [15:0] busVoltage;
    logic [15:0] speed;
    logic [15:0] devTemp;
    logic [15:0] paTemp;
    logic [15:0] qualifier;
    logic [31:0] detectTime;
    logic [31:0] powerOnCount;
    logic [15:0] enableCycles;
    logic [15:0] timeSinceEnable;
  } ehm_entry_s;

  localparam int ENTRY_W = $bits(ehm_entry_s);

  typedef enum logic {
    CLR_IDLE,
    CLR_BUSY
  } ehm_clr_state_e;

endpackage
